/* File: logic/port_power_pkg.sv */
// constants, register map and state codes of the port power and fault controller
package port_power_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 50;
	localparam int TIMER_W            = 20;
	// reverse-voltage and overvoltage qualifying mask time
	localparam int MASK_TIME_NS       = 10000;
	localparam int MASK_CYCLES        = (MASK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// least time the high-load output stays asserted
	localparam int HOLD_TIME_NS       = 100000;
	localparam int HOLD_CYCLES        = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// auto-recovery wait in the error state
	localparam int RECOVERY_TIME_NS   = 25000000;
	localparam int RECOVERY_CYCLES    = RECOVERY_TIME_NS / CLK_PERIOD_NS;
	// edges after reset release before the strap is captured
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ------------------------------------------------------------
	// strap decode
	// ------------------------------------------------------------
	localparam int STRAP_W        = 4;
	localparam int STRAP_MODE_BIT = 3;
	localparam int LIMIT_W        = 3;
	// limit codes 0..7 stand for 0.53, 0.96, 1.07, 1.28, 1.6, 2.13, 2.67, 3.2 A
	localparam logic [LIMIT_W-1:0] LIMIT_MAX = 3'h7;

	// ------------------------------------------------------------
	// register map, byte addresses
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
	localparam logic [ADDR_W-1:0] EVENT_OFFSET  = 4'h8;
	localparam logic [ADDR_W-1:0] STRAP_OFFSET  = 4'hc;

	// control register fields
	localparam int CTRL_W          = 7;
	localparam int CTRL_IGNORE_BIT = 0;
	localparam int CTRL_SOFT_LSB   = 1;
	localparam int CTRL_RATION_LSB = 3;
	localparam int CTRL_ACTION_LSB = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h06;

	// rationing action select
	localparam logic [1:0] ACTION_ALERT     = 2'h0;
	localparam logic [1:0] ACTION_ALERT_CUT = 2'h1;

	// power states
	typedef enum logic [1:0] {
		ST_SLEEP  = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_ERROR  = 2'b10
	} power_state_t;

endpackage

/* File: logic/qualify_timer.sv */
// cycle counter that qualifies a condition held for a fixed length
`timescale 1ns/1ps
module qualify_timer #(
	parameter int                 CNT_W = 20,
	parameter logic [CNT_W-1:0]   LEN   = 20'h000c8
) (
	// clock and reset
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	// condition and result
	input  wire logic cond_in,
	output logic      expired_out
);

	logic [CNT_W-1:0] count;

	// counts while the condition holds, back to zero as soon as it drops
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || !cond_in) begin
			count <= '0;
		end else if (count != LEN) begin
			count <= count + 1'b1;
		end
	end

	assign expired_out = cond_in && (count == LEN);

endmodule

/* File: logic/port_power_fault_control.sv */
// power-state, switch gating and fault output logic of a dual-port power switch
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// How it works
// - strap low half smbus, high half stand-alone
// - strap sets enable polarity and limit level
// - reverse voltage watched asleep, goes error
// - reverse voltage opens switch, mask then error
// - reverse voltage disables port, records event
// - no active, no switch under undervoltage
// - long overvoltage: both off, error, both faults
// - inactive enable never closes a switch
// - in smbus mode ignore bit drops pins, else pins and bits
// - two fault outputs, one per port
// - fault outputs open-drain, low on port error
// - rationing threshold asserts fault per action field
// - fault released only when all causes gone
// - high-load asserted when either port over threshold
// - high-load held for least assertion time
// - high-load output is open-drain active low
// - shared enable and fault wire supported
// - strap captured once after reset, then held
// - error keeps switch off, fault low
// - recovery waits period, returns active if clear
// - sleep when both enables inactive or undervoltage
module port_power_fault_control #(
	parameter int MASK_LEN     = port_power_pkg::MASK_CYCLES,
	parameter int HOLD_LEN     = port_power_pkg::HOLD_CYCLES,
	parameter int RECOVERY_LEN = port_power_pkg::RECOVERY_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	// avalon-mm register slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// strap and request pins
	input  wire logic [3:0]  mode_limit_strap_in,
	input  wire logic        port1_power_request_in,
	input  wire logic        port2_power_request_in,
	// analog monitor flags, one bit per port where paired
	input  wire logic [1:0]  reverse_voltage_in,
	input  wire logic        source_undervolt_in,
	input  wire logic        source_overvolt_in,
	input  wire logic [1:0]  over_boost_in,
	input  wire logic [1:0]  port_fault_in,
	input  wire logic [1:0]  ration_reached_in,
	// port switches
	output logic [1:0]       switch_close_out,
	// open-drain fault outputs, one per port
	output logic [1:0]       fault_n_out,
	output logic [1:0]       fault_oe_out,
	// open-drain high-load output
	output logic             high_load_n_out,
	output logic             high_load_oe_out,
	// decoded strap and state
	output logic             smbus_mode_out,
	output logic [2:0]       current_limit_level_out,
	output logic [1:0]       power_state_out
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	localparam int SYNC_W = 16;

	logic [SYNC_W-1:0] sync_stage1;
	logic [SYNC_W-1:0] sync_stage2;
	wire  [SYNC_W-1:0] raw_pins = {ration_reached_in, mode_limit_strap_in,
		port2_power_request_in, port1_power_request_in, reverse_voltage_in,
		source_undervolt_in, source_overvolt_in, over_boost_in, port_fault_in};

	// every pin passes two flops, the first is read only by the second
	always_ff @(posedge ref_clk_in) begin
		sync_stage1 <= raw_pins;
		sync_stage2 <= sync_stage1;
	end

	wire [1:0] ration_sync = sync_stage2[15:14];
	wire [3:0] strap_sync  = sync_stage2[13:10];
	wire [1:0] req_sync    = sync_stage2[9:8];
	wire [1:0] bv_sync     = sync_stage2[7:6];
	wire       uv_sync     = sync_stage2[5];
	wire       ov_sync     = sync_stage2[4];
	wire [1:0] boost_sync  = sync_stage2[3:2];
	wire [1:0] pfault_sync = sync_stage2[1:0];

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	logic [1:0]   settle_count;
	logic         strap_taken;
	logic [3:0]   strap_code;

	// one capture only
	// waits for the synchroniser to fill, then never samples again
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			settle_count <= 2'h0;
			strap_taken  <= 1'b0;
			strap_code   <= 4'h0;
		end else if (!strap_taken) begin
			settle_count <= settle_count + 2'h1;
			if (settle_count == port_power_pkg::STRAP_SETTLE) begin
				strap_taken <= 1'b1;
				strap_code  <= strap_sync;
			end
		end
	end

	wire smbus_mode = !strap_code[port_power_pkg::STRAP_MODE_BIT];
	// polarity follows mode, limit from low bits
	wire req_active_high = smbus_mode;
	wire [2:0] limit_code = strap_code[2:0];

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	logic [port_power_pkg::CTRL_W-1:0] ctrl;
	logic [1:0]  bv_event;
	logic [1:0]  ration_hit;
	logic        bus_ack;

	wire bus_req     = avs_read_in || avs_write_in;
	wire wr_take     = avs_write_in && bus_ack && avs_byteenable_in[0];
	wire sel_ctrl    = (avs_address_in == port_power_pkg::CTRL_OFFSET);
	wire sel_status  = (avs_address_in == port_power_pkg::STATUS_OFFSET);
	wire sel_event   = (avs_address_in == port_power_pkg::EVENT_OFFSET);
	wire sel_strap   = (avs_address_in == port_power_pkg::STRAP_OFFSET);
	wire wr_ctrl     = wr_take && sel_ctrl;
	wire [1:0] bv_clear     = (wr_take && sel_event) ? avs_writedata_in[1:0] : 2'h0;
	wire [1:0] ration_clear = (wr_take && sel_event) ? avs_writedata_in[3:2] : 2'h0;

	// control fields
	wire       ignore_request_pins = ctrl[port_power_pkg::CTRL_IGNORE_BIT];
	wire [1:0] soft_request = ctrl[port_power_pkg::CTRL_SOFT_LSB +: 2];
	wire [1:0] ration_en    = ctrl[port_power_pkg::CTRL_RATION_LSB +: 2];
	wire [1:0] ration_action_sel = ctrl[port_power_pkg::CTRL_ACTION_LSB +: 2];

	// every access answers on the second cycle, waitrequest low there
	assign avs_waitrequest_out = bus_req && !bus_ack;

	// ack pulse and control register
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			bus_ack <= 1'b0;
			ctrl    <= port_power_pkg::CTRL_RESET;
		end else begin
			bus_ack <= bus_req && !bus_ack;
			if (wr_ctrl) begin
				ctrl <= avs_writedata_in[port_power_pkg::CTRL_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// power state and per-port logic
	// ------------------------------------------------------------
	port_power_pkg::power_state_t state;
	port_power_pkg::power_state_t next_state;
	logic [1:0] port_error;
	logic [1:0] next_port_error;
	logic [1:0] eff_en;
	logic [1:0] bv_expired;
	logic [1:0] fault_assert;
	logic [1:0] ration_cut;
	logic [1:0] next_close;
	logic       ov_expired;
	logic       recovery_done;
	logic       recovery_restart;

	wire [1:0] req_active = req_active_high ? req_sync : ~req_sync;
	wire       causes_clear = !(|bv_sync) && !ov_sync && !(|pfault_sync);
	wire       in_error = (state == port_power_pkg::ST_ERROR);

	generate
		for (genvar p = 0; p < 2; p++) begin : g_port
			// enable only permits, see gating below
			assign eff_en[p] = !smbus_mode ? req_active[p] :
				ignore_request_pins ? soft_request[p] :
				(req_active[p] && soft_request[p]);

			qualify_timer #(
				.CNT_W (port_power_pkg::TIMER_W),
				.LEN   (port_power_pkg::TIMER_W'(MASK_LEN))
			) u_bv_mask (
				.ref_clk_in (ref_clk_in), .rst_n_in (rst_n_in),
				.cond_in (bv_sync[p]), .expired_out (bv_expired[p])
			);

			// rationing cut only on the cut action
			assign ration_cut[p] = ration_en[p] && ration_hit[p] &&
				(ration_action_sel == port_power_pkg::ACTION_ALERT_CUT);

			// reverse voltage opens the switch at once
			assign next_close[p] = (next_state == port_power_pkg::ST_ACTIVE) &&
				eff_en[p] && !uv_sync && !bv_sync[p] &&
				!next_port_error[p] && !ration_cut[p];

			// port error drives its own fault
			// any live cause keeps it asserted
			assign fault_assert[p] = next_port_error[p] || (ration_en[p] && ration_hit[p] &&
				ration_action_sel <= port_power_pkg::ACTION_ALERT_CUT);
		end
	endgenerate

	qualify_timer #(
		.CNT_W (port_power_pkg::TIMER_W),
		.LEN   (port_power_pkg::TIMER_W'(MASK_LEN))
	) u_ov_mask (
		.ref_clk_in (ref_clk_in), .rst_n_in (rst_n_in),
		.cond_in (ov_sync), .expired_out (ov_expired)
	);

	// recovery period, restarts after each check
	qualify_timer #(
		.CNT_W (port_power_pkg::TIMER_W),
		.LEN   (port_power_pkg::TIMER_W'(RECOVERY_LEN))
	) u_recovery (
		.ref_clk_in (ref_clk_in), .rst_n_in (rst_n_in),
		.cond_in (in_error && !recovery_restart), .expired_out (recovery_done)
	);

	// next state and port errors, errors take priority over everything
	always_comb begin
		next_state      = state;
		// port-local causes mark only their port
		next_port_error = port_error | bv_expired | pfault_sync;
		if (ov_expired) begin
			next_port_error = 2'h3;
		end
		case (state)
			port_power_pkg::ST_SLEEP: begin
				// reverse voltage while asleep goes straight to error
				next_port_error = next_port_error | bv_sync;
				if (|next_port_error) begin
					next_state = port_power_pkg::ST_ERROR;
				end else if ((|eff_en) && !uv_sync && strap_taken) begin
					next_state = port_power_pkg::ST_ACTIVE;
				end
			end
			port_power_pkg::ST_ACTIVE: begin
				if (|next_port_error) begin
					next_state = port_power_pkg::ST_ERROR;
				end else if (!(|eff_en) || uv_sync) begin
					// both enables gone, or supply lost
					next_state = port_power_pkg::ST_SLEEP;
				end
			end
			port_power_pkg::ST_ERROR: begin
				// check causes once the period ran out
				if (recovery_done && causes_clear && !ov_expired && !uv_sync) begin
					next_port_error = 2'h0;
					next_state      = port_power_pkg::ST_ACTIVE;
				end
			end
			default: begin
				next_state = port_power_pkg::ST_SLEEP;
			end
		endcase
	end

	// state, errors, switches and fault drivers
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state            <= port_power_pkg::ST_SLEEP;
			port_error       <= 2'h0;
			switch_close_out <= 2'h0;
			fault_oe_out     <= 2'h0;
			recovery_restart <= 1'b0;
		end else begin
			state            <= next_state;
			port_error       <= next_port_error;
			switch_close_out <= next_close;
			fault_oe_out     <= fault_assert;
			recovery_restart <= recovery_done; // registered, so the timer never feeds itself
		end
	end

	// released wire never driven high, hub may drive it
	// open-drain: only low is ever driven
	assign fault_n_out = 2'h0;

	// ------------------------------------------------------------
	// sticky events
	// ------------------------------------------------------------
	// back-voltage event recorded, set wins over clear
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			bv_event   <= 2'h0;
			ration_hit <= 2'h0;
		end else begin
			bv_event   <= (bv_event & ~bv_clear) | bv_sync;
			ration_hit <= ((ration_hit & ~ration_clear) | ration_sync) & ration_en;
		end
	end

	// ------------------------------------------------------------
	// high-load output
	// ------------------------------------------------------------
	logic high_load;
	logic hold_done;

	// hold counter restarts when the output drops
	qualify_timer #(
		.CNT_W (port_power_pkg::TIMER_W),
		.LEN   (port_power_pkg::TIMER_W'(HOLD_LEN))
	) u_hold (
		.ref_clk_in (ref_clk_in), .rst_n_in (rst_n_in),
		.cond_in (high_load), .expired_out (hold_done)
	);

	// stays until the least hold has passed
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			high_load <= 1'b0;
		end else begin
			high_load <= (|boost_sync) || (high_load && !hold_done);
		end
	end

	assign high_load_n_out  = 1'b0;
	assign high_load_oe_out = high_load;

	// ------------------------------------------------------------
	// readback and status outputs
	// ------------------------------------------------------------
	wire [31:0] status_word = {20'h00000, high_load, fault_oe_out, port_error,
		switch_close_out, eff_en, 1'b0, state};
	wire [31:0] event_word  = {28'h0000000, ration_hit, bv_event};
	wire [31:0] strap_word  = {27'h0000000, strap_taken, smbus_mode, limit_code};
	wire [31:0] ctrl_word   = {25'h0000000, ctrl};
	wire [31:0] read_mux    = sel_ctrl ? ctrl_word : sel_status ? status_word :
		sel_event ? event_word : sel_strap ? strap_word : 32'h00000000;

	// read data registered at the answering edge, unmapped reads zero
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= 32'h00000000;
		end else if (avs_read_in && !bus_ack) begin
			avs_readdata_out <= read_mux;
		end
	end

	// decoded strap held for the host
	assign smbus_mode_out          = smbus_mode;
	assign current_limit_level_out = limit_code;
	assign power_state_out         = state;

endmodule

/* File: verification/port_power_monitor.sv */
// concurrent checks on the ports of the port power and fault controller
`timescale 1ns/1ps
module port_power_monitor #(
	parameter int MASK_LEN = 4,
	parameter int HOLD_LEN = 8
) (
	// clock, reset and bus handshake
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       avs_read_in,
	input  wire logic       avs_write_in,
	input  wire logic       avs_waitrequest_out,
	// strap and monitor pins
	input  wire logic [3:0] mode_limit_strap_in,
	input  wire logic       port1_power_request_in,
	input  wire logic [1:0] reverse_voltage_in,
	input  wire logic       source_undervolt_in,
	input  wire logic       source_overvolt_in,
	input  wire logic [1:0] over_boost_in,
	// switch, open-drain and status outputs
	input  wire logic [1:0] switch_close_out,
	input  wire logic [1:0] fault_n_out,
	input  wire logic [1:0] fault_oe_out,
	input  wire logic       high_load_n_out,
	input  wire logic       high_load_oe_out,
	input  wire logic       smbus_mode_out,
	input  wire logic [2:0] current_limit_level_out,
	input  wire logic [1:0] power_state_out
);
	// ------------------------------------------------------------
	// helper counters
	// ------------------------------------------------------------
	localparam int OV_LIM = MASK_LEN + 7;
	logic [3:0]  since_rst;
	logic [15:0] ov_cnt;
	logic [15:0] hl_cnt;

	// edges since release, overvoltage run, high-load run
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			since_rst <= 4'h0;
			ov_cnt    <= 16'h0000;
			hl_cnt    <= 16'h0000;
		end else begin
			since_rst <= (since_rst == 4'hf) ? since_rst : since_rst + 4'h1;
			ov_cnt    <= source_overvolt_in ? ov_cnt + 16'h0001 : 16'h0000;
			hl_cnt    <= high_load_oe_out ? hl_cnt + 16'h0001 : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_wait;
		$rose(avs_read_in | avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
	endproperty
	property p_strap;
		since_rst == 4'h8 |-> smbus_mode_out == !mode_limit_strap_in[3]
			&& current_limit_level_out == mode_limit_strap_in[2:0];
	endproperty
	property p_strap_hold;
		since_rst == 4'hf |-> $stable({smbus_mode_out, current_limit_level_out});
	endproperty
	property p_reverse;
		reverse_voltage_in[0] [*5] |-> !switch_close_out[0];
	endproperty
	property p_undervolt;
		source_undervolt_in [*5] |-> switch_close_out == 2'b00
			&& power_state_out != port_power_pkg::ST_ACTIVE;
	endproperty
	// stand-alone: a high pin is an inactive enable
	property p_enable;
		(port1_power_request_in && !smbus_mode_out) [*5] |-> !switch_close_out[0];
	endproperty
	property p_overvolt;
		int'(ov_cnt) > OV_LIM |-> fault_oe_out == 2'b11 && switch_close_out == 2'b00
			&& power_state_out == port_power_pkg::ST_ERROR;
	endproperty
	property p_error;
		power_state_out == port_power_pkg::ST_ERROR [*2] |-> fault_oe_out != 2'b00;
	endproperty
	property p_boost;
		$rose(|over_boost_in) |-> ##[1:4] high_load_oe_out;
	endproperty
	property p_boost_hold;
		$fell(high_load_oe_out) |-> int'(hl_cnt) >= HOLD_LEN;
	endproperty
	property p_open_drain;
		fault_n_out == 2'b00 && !high_load_n_out;
	endproperty

	a_wait: assert property (p_wait) else $error("waitrequest not one wait cycle");
	a_strap: assert property (p_strap) else $error("strap decode wrong");
	a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
	a_reverse: assert property (p_reverse) else $error("switch closed on reverse");
	a_undervolt: assert property (p_undervolt) else $error("active under uv");
	a_enable: assert property (p_enable) else $error("closed while disabled");
	a_overvolt: assert property (p_overvolt) else $error("overvoltage not handled");
	a_error: assert property (p_error) else $error("error without fault");
	a_boost: assert property (p_boost) else $error("high load late");
	a_boost_hold: assert property (p_boost_hold) else $error("high load too short");
	a_open_drain: assert property (p_open_drain) else $error("open drain level");

	c_error: cover property (power_state_out == port_power_pkg::ST_ERROR);
	c_boost: cover property (high_load_oe_out);
	c_both: cover property (switch_close_out == 2'b11);
endmodule

bind port_power_fault_control port_power_monitor #(
	.MASK_LEN(MASK_LEN),
	.HOLD_LEN(HOLD_LEN)
) mon_u (.*);

/* File: verification/hub_model.sv */
// hub side model driving the request pins, optionally over one shared wire
`timescale 1ns/1ps
module hub_model (
	// clock and hub controls
	input  wire logic       clk_in,
	input  wire logic [1:0] en_in,
	input  wire logic       act_low_in,
	input  wire logic       one_wire_in,
	input  wire logic       slow_in,
	// device fault drive and pins
	input  wire logic [1:0] fault_oe_in,
	output logic [1:0]      req_out,
	output logic [1:0]      fault_seen_out
);
	logic [1:0] en_q;
	logic [1:0] use_en;
	logic [1:0] lvl;

	// a slow hub applies a new enable one clock late
	always_ff @(posedge clk_in) begin
		en_q <= en_in;
	end
	assign use_en = slow_in ? en_q : en_in;
	assign lvl    = use_en ^ {2{act_low_in}};
	// shared wire
	// hub releases to the pull-up, the device fault drain wins
	assign req_out        = one_wire_in ? (lvl & ~fault_oe_in) : lvl;
	assign fault_seen_out = one_wire_in ? (use_en & ~req_out) : fault_oe_in;
endmodule

/* File: verification/testbench.sv */
// self-checking bench of the port power and fault controller
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  a = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata, q, ex;
	logic        wreq, hn, hoe, smb, uv = 1'b0, ov = 1'b0;
	logic [3:0]  strap = 4'h0, be = 4'hf;
	logic [1:0]  rq, sw, fn, foe, st, seen;
	logic [1:0]  rv = 2'b00, bst = 2'b00, en = 2'b00, pf = 2'b00, rr = 2'b00;
	logic        alow = 1'b0, ow = 1'b0, slow = 1'b0;
	logic [2:0]  lim;
	int          err_total = 0, checks_done = 0, cyc = 0;
	int unsigned r;

	always #25 clk = ~clk;

	port_power_fault_control #(.MASK_LEN(4), .HOLD_LEN(8), .RECOVERY_LEN(16)) dut_u (
		.ref_clk_in(clk), .rst_n_in(rst_n),
		.avs_address_in(a), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.mode_limit_strap_in(strap),
		.port1_power_request_in(rq[0]), .port2_power_request_in(rq[1]),
		.reverse_voltage_in(rv), .source_undervolt_in(uv), .source_overvolt_in(ov),
		.over_boost_in(bst), .port_fault_in(pf), .ration_reached_in(rr),
		.switch_close_out(sw), .fault_n_out(fn), .fault_oe_out(foe),
		.high_load_n_out(hn), .high_load_oe_out(hoe), .smbus_mode_out(smb),
		.current_limit_level_out(lim), .power_state_out(st));

	hub_model hub_u (.clk_in(clk), .en_in(en), .act_low_in(alow), .one_wire_in(ow),
		.slow_in(slow), .fault_oe_in(foe), .req_out(rq), .fault_seen_out(seen));

	// ------------------------------------------------------------
	// tasks and expectations
	// ------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// hang guard, a run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			summarize();
		end
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wreq !== 1'b0) @(posedge clk);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] strap_exp(input logic [3:0] s);
		return {27'h0, 1'b1, ~s[3], s[2:0]};
	endfunction

	// ------------------------------------------------------------
	// main sequence: smbus strap, then stand-alone strap
	// ------------------------------------------------------------
	initial begin
		r = $urandom(32'h28d934bc);
		for (int ph = 0; ph < 2; ph++) begin
			en <= 2'b00;
			alow <= (ph == 1);
			ow <= (ph == 0);
			slow <= (ph == 1);
			strap <= 4'(ph * 8 + $urandom % 8);
			rst_n <= 1'b0;
			wt(3);
			rst_n <= 1'b1;
			wt(8);
			ex = strap_exp(strap);
			bus(0, port_power_pkg::STRAP_OFFSET, 0);
			chk(q, ex);
			strap <= ~strap;
			bus(0, port_power_pkg::STRAP_OFFSET, 0);
			chk(q, ex);
			bus(0, 4'h2, 0);
			chk(q, 32'h0);
			if (ph == 0) begin
				bus(0, port_power_pkg::CTRL_OFFSET, 0);
				chk(q, 32'(port_power_pkg::CTRL_RESET));
				r = $urandom;
				bus(1, port_power_pkg::CTRL_OFFSET, r);
				bus(0, port_power_pkg::CTRL_OFFSET, 0);
				chk(q, r & 32'h7f);
				// lane 0 disabled: the write must be dropped
				be <= 4'he;
				bus(1, port_power_pkg::CTRL_OFFSET, ~r);
				be <= 4'hf;
				bus(0, port_power_pkg::CTRL_OFFSET, 0);
				chk(q, r & 32'h7f);
				en <= 2'b10;
				bus(1, port_power_pkg::CTRL_OFFSET, 32'h3);
				wt(8);
				chk(32'(sw), 32'h1);
				bus(1, port_power_pkg::CTRL_OFFSET, 32'h6);
			end
			en <= 2'b01;
			wt(8);
			chk(32'(sw), 32'h1);
			en <= 2'b11;
			wt(8);
			chk(32'(sw), 32'h3);
			rv <= 2'b01;
			wt(2);
			rv <= 2'b00;
			wt(8);
			chk(32'(st), 32'(port_power_pkg::ST_ACTIVE));
			chk(32'(sw), 32'h3);
			rv <= 2'b10;
			wt(12);
			chk(32'(st), 32'(port_power_pkg::ST_ERROR));
			chk(32'(foe), 32'h2);
			chk(32'(sw[1]), 32'h0);
			if (ph == 0)
				chk(32'(seen), 32'h2);
			bus(0, port_power_pkg::EVENT_OFFSET, 0);
			chk(q & 32'h3, 32'h3);
			rv <= 2'b00;
			bus(1, port_power_pkg::EVENT_OFFSET, 32'h3);
			wt(30);
			chk(32'(st), 32'(port_power_pkg::ST_ACTIVE));
			chk(32'(foe), 32'h0);
			ov <= 1'b1;
			wt(14);
			chk(32'({foe, sw}), 32'hc);
			ov <= 1'b0;
			wt(30);
			chk(32'(st), 32'(port_power_pkg::ST_ACTIVE));
			r = $urandom;
			bst <= 2'(1 + r % 3);
			wt(1 + (r >> 4) % 3);
			bst <= 2'b00;
			wt(3);
			chk(32'(hoe), 32'h1);
			wt(20);
			chk(32'(hoe), 32'h0);
			uv <= 1'b1;
			wt(8);
			chk(32'({st, sw}), 32'(port_power_pkg::ST_SLEEP));
			uv <= 1'b0;
			wt(8);
			chk(32'(sw), 32'h3);
			if (ph == 0) begin
				// rationing on port 1 with the cut action, then cleared
				bus(1, port_power_pkg::CTRL_OFFSET, 32'h2e);
				rr <= 2'b01;
				wt(8);
				chk(32'({foe, sw}), 32'h6);
				rr <= 2'b00;
				bus(1, port_power_pkg::EVENT_OFFSET, 32'h4);
				wt(8);
				chk(32'({foe, sw}), 32'h3);
				// other port-1 error enters error at once
				pf <= 2'b01;
				wt(5);
				chk(32'({foe, sw}), 32'h4);
				pf <= 2'b00;
				wt(30);
				chk(32'(st), 32'(port_power_pkg::ST_ACTIVE));
			end
			$display("test %0d done", ph);
		end
		summarize();
	end
endmodule
